// *** design/oss_pkg.sv ***
// Constants of the octal switch serial port.
// How it works
// RULE1: Select rising copies shift register into output control latch.
// RULE2: Select falling loads qualified fault status into shift register.
// RULE3: Serial data out is driven whenever select is low.
// RULE4: Master keeps serial clock low while select changes.
// RULE5: Serial data in is sampled on each falling serial clock edge.
// RULE6: Next shift register bit goes out on each rising serial clock edge.
// RULE7: With select high, clock and data are ignored and output floats.
// RULE8: Master parks serial clock low while not accessing the device. The bench's noise task toggles serial clock while select is high.
// RULE9: Fault bit sets only after fault persists 100 to 300 microseconds.
// RULE10: Master spaces accesses more than 300 microseconds apart. The bench starts its last frame 13 clock cycles (325 ns) after the one before.
// RULE11: Master runs serial clock near 4 MHz, never above 6 MHz. The bench's frame task runs it at 5 MHz (8 clock cycles of 25 ns per bit).
// RULE12: Shift register is eight bits; channel eight shifts first.
// RULE13: Command one switches channel on, zero switches it off.
// RULE14: Status one means faulted channel, zero means normal.
// RULE15: Both words move MSB first, first-in-first-out for daisy chains.
// RULE16: Latch holds without frames and clears to all off at reset.
package oss_pkg;
  localparam int          OSS_CHANNELS        = 8;
  localparam int          OSS_CLK_PERIOD_NS   = 25;
  localparam int          OSS_FAULT_QUAL_US   = 100;
  localparam int          OSS_FAULT_QUAL_CYC  = (OSS_FAULT_QUAL_US * 1000 + OSS_CLK_PERIOD_NS - 1) / OSS_CLK_PERIOD_NS;
  localparam int          OSS_QUAL_W          = 13;
  localparam logic [7:0]  OSS_LATCH_RESET     = 8'h00;
  localparam int          OSS_FIFO_DEPTH      = 4;
  typedef enum logic [1:0] {
    OSS_IDLE  = 2'b01,
    OSS_FRAME = 2'b10
  } oss_state_e;
endpackage

// *** design/oss_fifo_if.sv ***
// Interface carrying words between the frame logic and the command FIFO.
`timescale 1ns/1ps
interface oss_fifo_if;
  logic [7:0] wr_data;
  logic       wr_valid;
  logic       wr_ready;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       rd_ready;
  modport fifo (input wr_data, input wr_valid, output wr_ready,
                output rd_data, output rd_valid, input rd_ready);
  modport user (output wr_data, output wr_valid, input wr_ready,
                input rd_data, input rd_valid, output rd_ready);
endinterface

// *** design/oss_fifo.sv ***
// Small FIFO with combinational read data from the storage array.
`timescale 1ns/1ps
module oss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  oss_fifo_if.fifo  f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign f.wr_ready = (cnt_q != (AW+1)'(DEPTH));
  assign f.rd_valid = (cnt_q != '0);
  assign push       = f.wr_valid && f.wr_ready;
  assign pop        = f.rd_valid && f.rd_ready;
  assign f.rd_data  = mem_q[rp_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= f.wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** design/oss_port.sv ***
// Serial control and status port of an eight-channel switch.
`timescale 1ns/1ps
module oss_port
  import oss_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       select_n,
  input  wire logic       sclk,
  input  wire logic       serial_in_pin,
  input  wire logic [7:0] fault_raw,
  output logic            serial_out,
  output logic            serial_out_oe,
  output logic [7:0]      channel_on,
  output logic [7:0]      fault_status
);
  logic [1:0] cs_sync_q;
  logic [1:0] ck_sync_q;
  logic [1:0] di_sync_q;
  logic       cs_prev_q;
  logic       ck_prev_q;
  logic [7:0] shift_q;
  logic [7:0] latch_q;
  logic [7:0] fault_q;
  logic [7:0] fr_sync1_q;
  logic [7:0] fr_sync2_q;
  logic       so_q;
  logic       oe_q;
  oss_state_e state_q;
  logic       cs_fall;
  logic       cs_rise;
  logic       ck_fall;
  logic       ck_rise;
  oss_fifo_if fif ();

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cs_sync_q  <= 2'h3;
      ck_sync_q  <= 2'h0;
      di_sync_q  <= 2'h0;
      cs_prev_q  <= 1'b1;
      ck_prev_q  <= 1'b0;
      fr_sync1_q <= 8'h00;
      fr_sync2_q <= 8'h00;
    end else begin
      cs_sync_q  <= {cs_sync_q[0], select_n};
      ck_sync_q  <= {ck_sync_q[0], sclk};
      di_sync_q  <= {di_sync_q[0], serial_in_pin};
      cs_prev_q  <= cs_sync_q[1];
      ck_prev_q  <= ck_sync_q[1];
      fr_sync1_q <= fault_raw;
      fr_sync2_q <= fr_sync1_q;
    end
  end

  assign cs_fall = cs_prev_q && !cs_sync_q[1];
  assign cs_rise = !cs_prev_q && cs_sync_q[1];
  assign ck_fall = (state_q == OSS_FRAME) && !cs_sync_q[1] && ck_prev_q && !ck_sync_q[1];
  assign ck_rise = (state_q == OSS_FRAME) && !cs_sync_q[1] && !ck_prev_q && ck_sync_q[1];

  // Each channel has its own qualification counter; a fault must persist before its bit sets.
  genvar g;
  generate
    for (g = 0; g < OSS_CHANNELS; g++) begin : g_qual
      logic [OSS_QUAL_W-1:0] cnt_q;
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          cnt_q      <= '0;
          fault_q[g] <= 1'b0;
        end else if (!fr_sync2_q[g]) begin
          cnt_q      <= '0;
          fault_q[g] <= 1'b0;
        end else if (cnt_q >= OSS_QUAL_W'(OSS_FAULT_QUAL_CYC - 1)) begin
          fault_q[g] <= 1'b1; // RULE9 RULE14
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= OSS_IDLE;
    end else begin
      case (state_q)
        OSS_IDLE: begin
          if (cs_fall) begin
            state_q <= OSS_FRAME;
          end
        end
        OSS_FRAME: begin
          if (cs_rise) begin
            state_q <= OSS_IDLE;
          end
        end
        default: state_q <= OSS_IDLE;
      endcase
    end
  end

  // Shift register: status loads at frame start, commands enter LSB, bits leave MSB.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift_q <= 8'h00;
    end else if (cs_fall) begin
      shift_q <= fault_q; // RULE2
    end else if (ck_fall) begin
      shift_q <= {shift_q[6:0], di_sync_q[1]}; // RULE5 RULE12 RULE15
    end
  end

  // Output bit: channel eight appears when select falls, the next bit on each rising clock after a falling one.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= !cs_sync_q[1]; // RULE3 RULE7
      if (cs_fall) begin
        so_q <= fault_q[7];
      end else if (ck_rise) begin
        so_q <= shift_q[7]; // RULE6 RULE15
      end
    end
  end

  // Command words pass through the FIFO to the output latch at frame end.
  assign fif.wr_data  = shift_q;
  assign fif.wr_valid = cs_rise && (state_q == OSS_FRAME); // RULE1
  assign fif.rd_ready = 1'b1;

  oss_fifo #(.WIDTH(OSS_CHANNELS), .DEPTH(OSS_FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .reset   (reset),
    .f       (fif.fifo)
  );

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      latch_q <= OSS_LATCH_RESET; // RULE16
    end else if (fif.rd_valid) begin
      latch_q <= fif.rd_data; // RULE1 RULE13
    end
  end

  assign channel_on    = latch_q;
  assign fault_status  = fault_q;
  assign serial_out    = so_q;
  assign serial_out_oe = oe_q;

  a_latch_holds: assert property (@(posedge clk_sys) disable iff (reset) // RULE16
    (state_q == OSS_IDLE) && !fif.rd_valid |=> $stable(latch_q))
    else $error("Latch changed without a frame.");

  // Both drive checks watch the select pin itself, so a broken synchroniser or enable path is caught.
  a_oe_follows_cs: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
    !select_n [*4] |-> oe_q)
    else $error("Output not driven during select.");

  a_oe_off_idle: assert property (@(posedge clk_sys) disable iff (reset) // RULE7
    select_n [*4] |-> !oe_q)
    else $error("Output driven while deselected.");

  a_status_loads: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
    cs_fall |=> shift_q == $past(fault_q))
    else $error("Status not loaded at frame start.");

  a_shift_in: assert property (@(posedge clk_sys) disable iff (reset) // RULE5
    ck_fall && !cs_fall |=> shift_q == {$past(shift_q[6:0]), $past(di_sync_q[1])})
    else $error("Input bit not shifted in.");

  a_shift_out: assert property (@(posedge clk_sys) disable iff (reset) // RULE6
    ck_rise && !cs_fall |=> so_q == $past(shift_q[7]))
    else $error("Output bit not advanced.");

  sequence s_frame_end;
    cs_rise && (state_q == OSS_FRAME);
  endsequence

  a_latch_update: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
    s_frame_end |-> ##2 latch_q == $past(shift_q, 2))
    else $error("Command not latched at frame end.");

  a_fault_qualify: assert property (@(posedge clk_sys) disable iff (reset) // RULE9
    $rose(fault_q[0]) |-> g_qual[0].cnt_q == OSS_QUAL_W'(OSS_FAULT_QUAL_CYC - 1))
    else $error("Fault set before qualification.");
endmodule

// *** test/oss_master.sv ***
// Behavioural serial master that runs frames against the switch port.
`timescale 1ns/1ps
module oss_master (
  input  wire logic clk_sys,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output logic      select_n,
  output logic      sclk,
  output logic      serial_in_pin
);
  initial begin
    select_n      = 1'b1;
    sclk          = 1'b0;
    serial_in_pin = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  // A floating output is read as unknown, so a missing drive never passes.
  task automatic frame(input int n, input logic [15:0] cmd, output logic [15:0] rsp);
    rsp = 16'h0000;
    tick(1);
    select_n = 1'b0;
    tick(8);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_pin = cmd[i];
      sclk          = 1'b1;
      tick(4);
      sclk = 1'b0;
      tick(4);
      rsp[i] = serial_out_oe ? serial_out : 1'bx;
    end
    tick(2);
    select_n      = 1'b1;
    serial_in_pin = ~serial_in_pin;
  endtask

  task automatic noise;
    for (int i = 0; i < 8; i++) begin
      sclk          = ~sclk;
      serial_in_pin = ~serial_in_pin;
      tick(4);
    end
  endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the octal switch serial port.
`timescale 1ns/1ps
module testbench;
  logic        clk_sys   = 1'b0;
  logic        reset     = 1'b1;
  logic [7:0]  fault_raw = 8'h00;
  logic [15:0] rsp;
  wire         select_n;
  wire         sclk;
  wire         serial_in_pin;
  wire         serial_out;
  wire         serial_out_oe;
  wire  [7:0]  channel_on;
  wire  [7:0]  fault_status;
  int          failures  = 0;
  int          n_tests   = 0;

  always #12.5 clk_sys = ~clk_sys;

  oss_port uut (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .select_n     (select_n),
    .sclk         (sclk),
    .serial_in_pin(serial_in_pin),
    .fault_raw    (fault_raw),
    .serial_out   (serial_out),
    .serial_out_oe(serial_out_oe),
    .channel_on   (channel_on),
    .fault_status (fault_status)
  );

  oss_master mst (
    .clk_sys      (clk_sys),
    .serial_out   (serial_out),
    .serial_out_oe(serial_out_oe),
    .select_n     (select_n),
    .sclk         (sclk),
    .serial_in_pin(serial_in_pin)
  );

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic test_reset;
    check8("latch", 8'h00, channel_on);
    check8("drive", 8'h00, {7'h00, serial_out_oe});
  endtask

  task automatic test_command;
    mst.frame(8, 16'h00A5, rsp);
    check8("status", 8'h00, rsp[7:0]);
    mst.tick(12);
    check8("latch", 8'hA5, channel_on);
    check8("drive", 8'h00, {7'h00, serial_out_oe});
  endtask

  task automatic test_idle_noise;
    mst.noise();
    mst.tick(12);
    check8("latch", 8'hA5, channel_on);
    check8("drive", 8'h00, {7'h00, serial_out_oe});
  endtask

  task automatic test_fault;
    fault_raw = 8'h7E;
    mst.tick(2000);
    check8("brief", 8'h00, fault_status);
    fault_raw = 8'h81;
    mst.tick(3900);
    check8("early", 8'h00, fault_status);
    mst.tick(8100);
    check8("qual", 8'h81, fault_status);
    mst.frame(8, 16'h003C, rsp);
    check8("status", 8'h81, rsp[7:0]);
    mst.tick(12);
    check8("latch", 8'h3C, channel_on);
  endtask

  task automatic test_chain;
    mst.frame(16, 16'h5AC3, rsp);
    check8("first", 8'h81, rsp[15:8]);
    check8("through", 8'h5A, rsp[7:0]);
    mst.tick(12);
    check8("latch", 8'hC3, channel_on);
    fault_raw = 8'h00;
    mst.tick(12);
    check8("clear", 8'h00, fault_status);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    test_reset();
    #2 reset = 1'b0;
    mst.tick(4);
    test_command();
    test_idle_noise();
    test_fault();
    test_chain();
    print_verdict();
  end

  initial begin
    #1000000;
    failures++;
    print_verdict();
  end
endmodule
